// ---- jtdr_pkg.sv ----
`default_nettype none
package jtdr_pkg;
	// ---------------------------------------------------------------
	// instruction codes
	// ---------------------------------------------------------------
	localparam int          IR_W          = 3;
	localparam logic [2:0]  IR_EXTEST     = 3'h0;
	localparam logic [2:0]  IR_IDCODE     = 3'h1;
	localparam logic [2:0]  IR_SAMPLE     = 3'h2;
	localparam logic [2:0]  IR_CLAMP      = 3'h3;
	localparam logic [2:0]  IR_HIGHZ      = 3'h4;
	localparam logic [2:0]  IR_BYPASS     = 3'h7;
	// ---------------------------------------------------------------
	// identification layout
	// ---------------------------------------------------------------
	localparam int          ID_W          = 32;
	localparam int          ID_REV_W      = 4;
	localparam int          ID_PART_W     = 16;
	localparam int          ID_MFR_W      = 11;
	localparam logic        ID_FIXED_BIT  = 1'b1;
	localparam logic        BYP_CAPTURE   = 1'b0;
	localparam int          BSR_W         = 8;
	// ---------------------------------------------------------------
	// tap states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
		TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} jtdr_tap_e;
	typedef enum logic [1:0] {SEL_BYPASS, SEL_BSR, SEL_ID} jtdr_sel_e;
endpackage
`default_nettype wire

// ---- jtdr_sync.sv ----
`default_nettype none
module jtdr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule // jtdr_sync
`default_nettype wire

// ---- jtdr_tap.sv ----
`default_nettype none
module jtdr_tap (
	// link clock
	input  wire logic               test_clock,
	input  wire logic               tap_rst,
	// mode select
	input  wire logic               test_mode_select,
	// state
	output jtdr_pkg::jtdr_tap_e     state_ff
);
	jtdr_pkg::jtdr_tap_e nxt_state;
	wire logic tms = test_mode_select;
	always_comb begin
		unique case (state_ff)
			jtdr_pkg::TAP_RESET:  nxt_state = tms ? jtdr_pkg::TAP_RESET  : jtdr_pkg::TAP_IDLE;
			jtdr_pkg::TAP_IDLE:   nxt_state = tms ? jtdr_pkg::TAP_SEL_DR : jtdr_pkg::TAP_IDLE;
			jtdr_pkg::TAP_SEL_DR: nxt_state = tms ? jtdr_pkg::TAP_SEL_IR : jtdr_pkg::TAP_CAP_DR;
			jtdr_pkg::TAP_CAP_DR: nxt_state = tms ? jtdr_pkg::TAP_EX1_DR : jtdr_pkg::TAP_SH_DR;
			jtdr_pkg::TAP_SH_DR:  nxt_state = tms ? jtdr_pkg::TAP_EX1_DR : jtdr_pkg::TAP_SH_DR;
			jtdr_pkg::TAP_EX1_DR: nxt_state = tms ? jtdr_pkg::TAP_UPD_DR : jtdr_pkg::TAP_PA_DR;
			jtdr_pkg::TAP_PA_DR:  nxt_state = tms ? jtdr_pkg::TAP_EX2_DR : jtdr_pkg::TAP_PA_DR;
			jtdr_pkg::TAP_EX2_DR: nxt_state = tms ? jtdr_pkg::TAP_UPD_DR : jtdr_pkg::TAP_SH_DR;
			jtdr_pkg::TAP_UPD_DR: nxt_state = tms ? jtdr_pkg::TAP_SEL_DR : jtdr_pkg::TAP_IDLE;
			jtdr_pkg::TAP_SEL_IR: nxt_state = tms ? jtdr_pkg::TAP_RESET  : jtdr_pkg::TAP_CAP_IR;
			jtdr_pkg::TAP_CAP_IR: nxt_state = tms ? jtdr_pkg::TAP_EX1_IR : jtdr_pkg::TAP_SH_IR;
			jtdr_pkg::TAP_SH_IR:  nxt_state = tms ? jtdr_pkg::TAP_EX1_IR : jtdr_pkg::TAP_SH_IR;
			jtdr_pkg::TAP_EX1_IR: nxt_state = tms ? jtdr_pkg::TAP_UPD_IR : jtdr_pkg::TAP_PA_IR;
			jtdr_pkg::TAP_PA_IR:  nxt_state = tms ? jtdr_pkg::TAP_EX2_IR : jtdr_pkg::TAP_PA_IR;
			jtdr_pkg::TAP_EX2_IR: nxt_state = tms ? jtdr_pkg::TAP_UPD_IR : jtdr_pkg::TAP_SH_IR;
			jtdr_pkg::TAP_UPD_IR: nxt_state = tms ? jtdr_pkg::TAP_SEL_DR : jtdr_pkg::TAP_IDLE;
		endcase
	end
	always_ff @(posedge test_clock) begin
		if (tap_rst) begin
			state_ff <= jtdr_pkg::TAP_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end
endmodule // jtdr_tap
`default_nettype wire

// ---- jtdr_top.sv ----
// Behaviour
// - bypass, boundary scan and identification registers present
// - one-bit bypass for BYPASS, CLAMP, HIGHZ
// - boundary scan shift path plus latched output
// - identification: 32-bit shift plus latched copy that drives no output
// - identification selected by IDCODE or reset state
// - id = revision, part, maker, fixed one
// - three-bit instruction codes select data register
// - capture-dr with IDCODE loads identification value
// - only selected register shifts in shift-dr
`default_nettype none
module jtdr_top #(
	parameter int                        BSR_W   = jtdr_pkg::BSR_W,
	parameter logic [jtdr_pkg::ID_REV_W-1:0]  ID_REV  = 4'h0,    // arbitrary value
	parameter logic [jtdr_pkg::ID_PART_W-1:0] ID_PART = 16'h0000, // arbitrary value
	parameter logic [jtdr_pkg::ID_MFR_W-1:0]  ID_MFR  = 11'h000   // arbitrary value
) (
	// system clock and reset
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// test port, link domain
	input  wire logic             test_clock,
	input  wire logic             test_mode_select,
	input  wire logic             test_data_in,
	output logic                  test_data_out,
	output logic                  test_data_out_oe_n,
	// boundary cells, system domain
	input  wire logic [BSR_W-1:0] bsr_pin_in,
	output logic      [BSR_W-1:0] bsr_pin_out,
	output logic                  bsr_pin_drive,
	output logic                  bsr_pin_highz,
	output logic      [2:0]       cur_instr
);
	// ---------------------------------------------------------------
	// reset and pin crossing into link domain
	// ---------------------------------------------------------------
	logic tap_rst;
	jtdr_sync #(.W(1)) u_rst_sync (
		.clk  (test_clock),
		.srst (1'b0),
		.d    (srst),
		.q    (tap_rst)
	);
	logic [BSR_W-1:0] pins_tck;
	jtdr_sync #(.W(BSR_W)) u_pin_sync (
		.clk  (test_clock),
		.srst (tap_rst),
		.d    (bsr_pin_in),
		.q    (pins_tck)
	);
	// ---------------------------------------------------------------
	// tap state
	// ---------------------------------------------------------------
	jtdr_pkg::jtdr_tap_e state;
	jtdr_tap u_tap (
		.test_clock       (test_clock),
		.tap_rst          (tap_rst),
		.test_mode_select (test_mode_select),
		.state_ff         (state)
	);
	wire logic in_reset = (state == jtdr_pkg::TAP_RESET);
	wire logic cap_dr   = (state == jtdr_pkg::TAP_CAP_DR);
	wire logic sh_dr    = (state == jtdr_pkg::TAP_SH_DR);
	wire logic upd_dr   = (state == jtdr_pkg::TAP_UPD_DR);
	wire logic cap_ir   = (state == jtdr_pkg::TAP_CAP_IR);
	wire logic sh_ir    = (state == jtdr_pkg::TAP_SH_IR);
	wire logic upd_ir   = (state == jtdr_pkg::TAP_UPD_IR);
	// ---------------------------------------------------------------
	// instruction register
	// ---------------------------------------------------------------
	logic [jtdr_pkg::IR_W-1:0] ir_sh_ff;
	logic [jtdr_pkg::IR_W-1:0] ir_ff;
	logic [jtdr_pkg::IR_W-1:0] nxt_ir_sh;
	assign nxt_ir_sh = cap_ir ? jtdr_pkg::IR_IDCODE :
		sh_ir ? {test_data_in, ir_sh_ff[jtdr_pkg::IR_W-1:1]} : ir_sh_ff;
	always_ff @(posedge test_clock) begin
		if (tap_rst) begin
			ir_sh_ff <= jtdr_pkg::IR_IDCODE;
		end else begin
			ir_sh_ff <= nxt_ir_sh;
		end
	end
	// latched on falling edge; reset state forces IDCODE
	always_ff @(negedge test_clock) begin
		if (tap_rst || in_reset) begin
			ir_ff <= jtdr_pkg::IR_IDCODE;
		end else if (upd_ir) begin
			ir_ff <= ir_sh_ff;
		end
	end
	// ---------------------------------------------------------------
	// register selection
	// ---------------------------------------------------------------
	function automatic jtdr_pkg::jtdr_sel_e dec_sel(input logic [2:0] code);
		unique case (code)
			jtdr_pkg::IR_EXTEST, jtdr_pkg::IR_SAMPLE: dec_sel = jtdr_pkg::SEL_BSR;
			jtdr_pkg::IR_IDCODE:                      dec_sel = jtdr_pkg::SEL_ID;
			default:                                  dec_sel = jtdr_pkg::SEL_BYPASS;
		endcase
	endfunction
	jtdr_pkg::jtdr_sel_e sel;
	assign sel = in_reset ? jtdr_pkg::SEL_ID : dec_sel(ir_ff);
	wire logic sel_byp = (sel == jtdr_pkg::SEL_BYPASS);
	wire logic sel_bsr = (sel == jtdr_pkg::SEL_BSR);
	wire logic sel_id  = (sel == jtdr_pkg::SEL_ID);
	// ---------------------------------------------------------------
	// bypass stage
	// ---------------------------------------------------------------
	logic byp_ff;
	logic nxt_byp;
	assign nxt_byp = (sel_byp && cap_dr) ? jtdr_pkg::BYP_CAPTURE :
		(sel_byp && sh_dr) ? test_data_in : byp_ff;
	always_ff @(posedge test_clock) begin
		if (tap_rst) begin
			byp_ff <= jtdr_pkg::BYP_CAPTURE;
		end else begin
			byp_ff <= nxt_byp;
		end
	end
	// ---------------------------------------------------------------
	// identification register
	// ---------------------------------------------------------------
	wire logic [jtdr_pkg::ID_W-1:0] id_value = {ID_REV, ID_PART, ID_MFR, jtdr_pkg::ID_FIXED_BIT};
	logic [jtdr_pkg::ID_W-1:0] id_sh_ff;
	logic [jtdr_pkg::ID_W-1:0] id_par_ff;
	logic [jtdr_pkg::ID_W-1:0] nxt_id_sh;
	assign nxt_id_sh = (sel_id && cap_dr) ? id_value :
		(sel_id && sh_dr) ? {test_data_in, id_sh_ff[jtdr_pkg::ID_W-1:1]} : id_sh_ff;
	always_ff @(posedge test_clock) begin
		if (tap_rst) begin
			id_sh_ff <= id_value;
		end else begin
			id_sh_ff <= nxt_id_sh;
		end
	end
	always_ff @(negedge test_clock) begin
		if (tap_rst) begin
			id_par_ff <= '0;
		end else if (sel_id && upd_dr) begin
			id_par_ff <= id_sh_ff;
		end
	end
	// ---------------------------------------------------------------
	// boundary scan register
	// ---------------------------------------------------------------
	logic [BSR_W-1:0] bsr_sh_ff;
	logic [BSR_W-1:0] bsr_par_ff;
	logic [BSR_W-1:0] nxt_bsr_sh;
	assign nxt_bsr_sh = (sel_bsr && cap_dr) ? pins_tck :
		(sel_bsr && sh_dr) ? {test_data_in, bsr_sh_ff[BSR_W-1:1]} : bsr_sh_ff;
	always_ff @(posedge test_clock) begin
		if (tap_rst) begin
			bsr_sh_ff <= '0;
		end else begin
			bsr_sh_ff <= nxt_bsr_sh;
		end
	end
	always_ff @(negedge test_clock) begin
		if (tap_rst) begin
			bsr_par_ff <= '0;
		end else if (sel_bsr && upd_dr) begin
			bsr_par_ff <= bsr_sh_ff;
		end
	end
	// ---------------------------------------------------------------
	// serial output, changes on falling edge
	// ---------------------------------------------------------------
	wire logic tdo_mux = sh_ir ? ir_sh_ff[0] :
		sel_id ? id_sh_ff[0] : sel_bsr ? bsr_sh_ff[0] : byp_ff;
	always_ff @(negedge test_clock) begin
		if (tap_rst) begin
			test_data_out      <= 1'b0;
			test_data_out_oe_n <= 1'b1;
		end else begin
			test_data_out      <= tdo_mux;
			test_data_out_oe_n <= !(sh_dr || sh_ir);
		end
	end
	// ---------------------------------------------------------------
	// crossing to system domain
	// ---------------------------------------------------------------
	wire logic [BSR_W+2:0] ctl_tck = {bsr_par_ff, ir_ff};
	logic [BSR_W+2:0] ctl_sys;
	jtdr_sync #(.W(BSR_W+3)) u_ctl_sync (
		.clk  (clk_sys),
		.srst (srst),
		.d    (ctl_tck),
		.q    (ctl_sys)
	);
	// word taken only once two samples agree, so a torn crossing never reaches the pins
	logic [BSR_W+2:0] ctl_prev_ff;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctl_prev_ff <= '0;
		end else begin
			ctl_prev_ff <= ctl_sys;
		end
	end
	wire logic       ctl_steady = (ctl_sys == ctl_prev_ff);
	wire logic [2:0] instr_sys  = ctl_sys[2:0];
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cur_instr     <= jtdr_pkg::IR_IDCODE;
			bsr_pin_out   <= '0;
			bsr_pin_drive <= 1'b0;
			bsr_pin_highz <= 1'b0;
		end else if (ctl_steady) begin
			cur_instr     <= instr_sys;
			bsr_pin_out   <= ctl_sys[BSR_W+2:3];
			bsr_pin_drive <= (instr_sys == jtdr_pkg::IR_EXTEST) || (instr_sys == jtdr_pkg::IR_CLAMP);
			bsr_pin_highz <= (instr_sys == jtdr_pkg::IR_HIGHZ);
		end
	end
endmodule // jtdr_top
`default_nettype wire

// ---- jtdr_monitor.sv ----
`default_nettype none
module jtdr_monitor #(
	parameter int BSR_W = 8
) (
	// system side
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic [BSR_W-1:0] bsr_pin_in,
	input  wire logic [BSR_W-1:0] bsr_pin_out,
	input  wire logic             bsr_pin_drive,
	input  wire logic             bsr_pin_highz,
	input  wire logic [2:0]       cur_instr,
	// test port
	input  wire logic             test_clock,
	input  wire logic             test_mode_select,
	input  wire logic             test_data_in,
	input  wire logic             test_data_out,
	input  wire logic             test_data_out_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// tap next-state tables, one nibble per state
	localparam logic [63:0] NX0 = 64'h1bddbba1_46644311;
	localparam logic [63:0] NX1 = 64'h2fefcc02_87855920;
	logic [3:0] st_ff;
	wire logic  byp = cur_instr[2] | (cur_instr == jtdr_pkg::IR_CLAMP);
	always_ff @(posedge test_clock) begin
		st_ff <= srst ? 4'h0 : (test_mode_select ? NX1[{st_ff, 2'b00} +: 4] : NX0[{st_ff, 2'b00} +: 4]);
	end
	AST_OE_SHIFT: assert property (@(posedge test_clock) disable iff (srst)
		test_data_out_oe_n == !(st_ff == 4'h4 || st_ff == 4'hb)) else $error("oe_n outside shift");
	AST_BYP_ZERO: assert property (@(posedge test_clock) disable iff (srst)
		st_ff == 4'h4 && $past(st_ff) == 4'h3 && byp |-> !test_data_out) else $error("bypass capture");
	AST_BYP_PASS: assert property (@(posedge test_clock) disable iff (srst)
		st_ff == 4'h4 && $past(st_ff) == 4'h4 && byp |-> test_data_out == $past(test_data_in))
		else $error("bypass path");
	AST_ID_FIXED: assert property (@(posedge test_clock) disable iff (srst)
		st_ff == 4'h4 && $past(st_ff) == 4'h3 && cur_instr == jtdr_pkg::IR_IDCODE |-> test_data_out)
		else $error("id fixed bit");
	AST_RESET_ID: assert property (@(posedge test_clock) disable iff (srst)
		st_ff == 4'h0 && $past(st_ff) == 4'h0 |-> ##[1:4] cur_instr == jtdr_pkg::IR_IDCODE)
		else $error("reset instr");
	AST_DRIVE: assert property (@(posedge clk_sys) disable iff (srst)
		(cur_instr == jtdr_pkg::IR_EXTEST || cur_instr == jtdr_pkg::IR_CLAMP) [*3] |-> bsr_pin_drive && !bsr_pin_highz)
		else $error("drive");
	AST_HIGHZ: assert property (@(posedge clk_sys) disable iff (srst)
		(cur_instr == jtdr_pkg::IR_HIGHZ) [*3] |-> bsr_pin_highz && !bsr_pin_drive) else $error("highz");
	AST_BSR_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
		$changed(bsr_pin_out) |-> cur_instr == jtdr_pkg::IR_EXTEST || cur_instr == jtdr_pkg::IR_SAMPLE)
		else $error("bsr output changed");
endmodule // jtdr_monitor
`default_nettype wire

// ---- jtdr_tester.sv ----
`default_nettype none
module jtdr_tester (
	// test port
	output logic test_clock,
	output logic test_mode_select,
	output logic test_data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		test_clock = 1'b0;
		test_mode_select = 1'b1;
		test_data_in = 1'b0;
	end
	// one 12 ns period; clock rests low between calls
	task automatic tck(input logic m, input logic d);
		#1.3;
		test_mode_select = m;
		test_data_in = d;
		#4.7 test_clock = 1'b1;
		#6 test_clock = 1'b0;
		test_data_in = ~d;
	endtask
endmodule // jtdr_tester
`default_nettype wire

// ---- test_jtdr_top.sv ----
`default_nettype none
module test_jtdr_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int          BW = 8;
	localparam logic [31:0] ID = {4'ha, 16'h5c3e, 11'h2b1, 1'b1}; // arbitrary values
	localparam logic [2:0]  CODES [7] = '{jtdr_pkg::IR_SAMPLE, jtdr_pkg::IR_EXTEST, jtdr_pkg::IR_CLAMP,
		jtdr_pkg::IR_HIGHZ, 3'h5, jtdr_pkg::IR_BYPASS, jtdr_pkg::IR_IDCODE};
	logic          clk_sys = 1'b0;
	logic          srst = 1'b1;
	logic [BW-1:0] pins = '0;
	logic [31:0]   seed = 32'h354caeb8;
	logic          exp_q [$];
	int            n_fail = 0;
	int            n_tests = 0;
	int            cyc = 0;
	wire logic     tck_w, tms_w, tdi_w, tdo, oe_n, drv, hz;
	wire logic [BW-1:0] pout;
	wire logic [2:0]    instr;
	jtdr_top #(.BSR_W(BW), .ID_REV(4'ha), .ID_PART(16'h5c3e), .ID_MFR(11'h2b1)) u_dut (
		.clk_sys(clk_sys), .srst(srst), .test_clock(tck_w), .test_mode_select(tms_w),
		.test_data_in(tdi_w), .test_data_out(tdo), .test_data_out_oe_n(oe_n), .bsr_pin_in(pins),
		.bsr_pin_out(pout), .bsr_pin_drive(drv), .bsr_pin_highz(hz), .cur_instr(instr));
	jtdr_tester u_tester (.test_clock(tck_w), .test_mode_select(tms_w), .test_data_in(tdi_w));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic fail_msg(input logic bad);
		n_tests++;
		if (bad) begin
			n_fail++;
			$display("[FAIL] %0t value mismatch", $time);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		fail_msg(got !== exp);
	endtask
	task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp);
		fail_msg(got !== exp);
	endtask
	task automatic print_verdict();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic [31:0] exp);
		u_tester.tck(1'b1, 1'b0);
		if (ir) u_tester.tck(1'b1, 1'b0);
		u_tester.tck(1'b0, 1'b0);
		u_tester.tck(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(exp[i]);
			u_tester.tck(i == n - 1, din[i]);
		end
		u_tester.tck(1'b1, 1'b0);
		u_tester.tck(1'b0, 1'b0);
	endtask
	// ---------------------------------------------------------------
	// clock, timeout, tdo watcher
	// ---------------------------------------------------------------
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	always @(posedge tck_w) begin
		if (oe_n === 1'b0) cmp_bit(tdo, exp_q.size() > 0 ? exp_q.pop_front() : 1'bx);
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [2:0]  c;
		logic [7:0]  last;
		logic        bs;
		last = '0;
		repeat (6) u_tester.tck(1'b1, 1'b0);
		@(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (4) u_tester.tck(1'b1, 1'b0);
		u_tester.tck(1'b0, 1'b0);
		scan(1'b0, 32, rnd(), ID);
		foreach (CODES[k]) begin
			c = CODES[k];
			scan(1'b1, 3, {29'h0, c}, 32'h1);
			repeat (10) @(posedge clk_sys);
			#1 cmp_vec(8'(instr), 8'(c));
			cmp_vec({6'h0, hz, drv}, {6'h0, c == jtdr_pkg::IR_HIGHZ, c == 3'h0 || c == 3'h3});
			bs = (c == jtdr_pkg::IR_EXTEST || c == jtdr_pkg::IR_SAMPLE);
			pins = BW'(rnd());
			d = rnd();
			u_tester.tck(1'b0, 1'b0);
			scan(1'b0, bs ? BW : (c == 3'h1 ? 32 : 8), d, bs ? 32'(pins) : (c == 3'h1 ? ID : {d[30:0], 1'b0}));
			if (bs) last = d[BW-1:0];
			repeat (10) @(posedge clk_sys);
			#1 cmp_vec(pout, last);
		end
		scan(1'b1, 3, 32'h7, 32'h1);
		repeat (5) u_tester.tck(1'b1, 1'b0);
		u_tester.tck(1'b0, 1'b0);
		scan(1'b0, 32, rnd(), ID);
		repeat (10) @(posedge clk_sys);
		#1 cmp_vec(8'(instr), 8'(jtdr_pkg::IR_IDCODE));
		cmp_vec(8'(exp_q.size()), 8'h0);
		print_verdict();
	end
endmodule // test_jtdr_top
bind jtdr_top jtdr_monitor #(.BSR_W(BSR_W)) u_mon (.clk_sys, .srst, .bsr_pin_in, .bsr_pin_out, .bsr_pin_drive,
	.bsr_pin_highz, .cur_instr, .test_clock, .test_mode_select, .test_data_in, .test_data_out, .test_data_out_oe_n);
`default_nettype wire
